// ==== hw/psr_defines.vh ====
// Constants for the pressure sensor I2C readout block
// Overview of operation
// - Device answers as an I2C target at 7-bit address 0x6D.
// - START is SDA falling while SCL is high.
// - After START: seven address bits, then one read/write direction bit.
// - On address match, device pulls SDA low in the ninth clock.
// - STOP is SDA rising while SCL is high.
// - SDA driver changes data only while SCL is low.
// - Single-byte register write and single-byte register read are supported.
// - Pressure is 24 bits over three read-only registers, MSB lowest.
// - Temperature is 16 bits over two read-only registers, high byte first.
// - Start flag begins conversion; self-clears at end, except sleep mode.
// - Kind 010 runs temperature then pressure conversion once.
// - Kind 011 repeats combined conversions separated by the idle interval.
// - Idle field: 62.5 ms steps, 0 to 937.5 ms, used in sleep only.
// - Regulator select: 0 gives 1.8 V, 1 gives 3.6 V.
// - Raw select: 0 calibrated results, 1 raw converter data.
// - Format bit: 0 signed, 1 unsigned, only with raw output.
// - Diagnosis enable bit 1 enables diagnosis; default on.
// - Polarity swap exchanges positive and negative bridge inputs.
// - Gain field selects gain of two to the field value.
// - Oversampling field maps to 1024..8192, then 256, 512, 16384, 32768.
// - Pressure MSB is a sign bit: 1 negative, 0 positive.
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH
`define PSR_I2C_ADDR      7'h6D
`define PSR_REG_P_HIGH    8'h06
`define PSR_REG_P_MID     8'h07
`define PSR_REG_P_LOW     8'h08
`define PSR_REG_T_HIGH    8'h09
`define PSR_REG_T_LOW     8'h0A
`define PSR_REG_CMD       8'h30
`define PSR_REG_SYS       8'hA5
`define PSR_REG_CHAN      8'hA6
`define PSR_CMD_RESET     8'h00
`define PSR_SYS_RESET     8'h02
`define PSR_CHAN_RESET    8'h00
`define PSR_START_BIT     3
`define PSR_KIND_COMBINED 3'b010
`define PSR_KIND_SLEEP    3'b011
`define PSR_SYS_DIAG      1
`define PSR_SYS_RAW       2
`define PSR_SYS_UNSIGNED  3
`define PSR_SYS_REGSEL    4
`define PSR_CHAN_SWAP     6
`define PSR_CLK_MHZ       125
`define PSR_IDLE_STEP_US  62500
`define PSR_IDLE_STEP_CYC (`PSR_IDLE_STEP_US * `PSR_CLK_MHZ)
`define PSR_CONV_US       2500
`define PSR_CONV_CYC      (`PSR_CONV_US * `PSR_CLK_MHZ)
`endif

// ==== hw/psr_readout.v ====
// I2C target with conversion sequencer and result registers
`timescale 1ns/1ns
`default_nettype none
`include "psr_defines.vh"
module psr_readout #(
  parameter [31:0] CONV_CYC      = `PSR_CONV_CYC,
  parameter [31:0] IDLE_STEP_CYC = `PSR_IDLE_STEP_CYC
) (
  input  wire        clk_i,          // 125 MHz clock
  input  wire        rst_i,          // Async reset, active high
  input  wire        ce_i,           // Clock enable
  input  wire        scl_i,          // Bus clock pin
  input  wire        sda_i,          // Bus data pin in
  output reg         sda_o,          // Bus data out, always 0
  output reg         sda_oe_o,       // Pull data line low
  input  wire [23:0] adc_press_i,    // Pressure converter sample
  input  wire [15:0] adc_temp_i,     // Temperature converter sample
  input  wire [23:0] cal_press_i,    // Calibrated pressure
  input  wire [15:0] cal_temp_i,     // Calibrated temperature
  output reg         conv_temp_o,    // Temperature conversion active
  output reg         conv_press_o,   // Pressure conversion active
  output reg         reg_3v6_o,      // Regulator at 3.6 V
  output reg         diag_en_o,      // Diagnosis enabled
  output reg         in_swap_o,      // Swap bridge inputs
  output reg  [7:0]  gain_o,         // Channel gain factor
  output reg  [15:0] osr_o           // Oversampling ratio
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_TEMP = 5'h02;
  localparam [4:0] ST_PRES = 5'h04;
  localparam [4:0] ST_WAIT = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  localparam [5:0] BS_IDLE = 6'h01;
  localparam [5:0] BS_ADDR = 6'h02;
  localparam [5:0] BS_RX   = 6'h04;
  localparam [5:0] BS_TX   = 6'h08;
  localparam [5:0] BS_ACK  = 6'h10;
  localparam [5:0] BS_MACK = 6'h20;

  function [15:0] osr_map;
    input [2:0] f;
    begin
      case (f)
        3'h0: osr_map = 16'h0400;
        3'h1: osr_map = 16'h0800;
        3'h2: osr_map = 16'h1000;
        3'h3: osr_map = 16'h2000;
        3'h4: osr_map = 16'h0100;
        3'h5: osr_map = 16'h0200;
        3'h6: osr_map = 16'h4000;
        default: osr_map = 16'h8000;
      endcase
    end
  endfunction

  // Pin synchronisers
  reg [1:0] scl_s_reg;
  reg [1:0] sda_s_reg;
  reg       scl_d_reg;
  reg       sda_d_reg;
  wire scl_w = scl_s_reg[1];
  wire sda_w = sda_s_reg[1];
  wire scl_rise = scl_w & ~scl_d_reg;
  wire scl_fall = ~scl_w & scl_d_reg;
  wire start_det = scl_w & scl_d_reg & sda_d_reg & ~sda_w;
  wire stop_det  = scl_w & scl_d_reg & ~sda_d_reg & sda_w;

  reg [7:0]  cmd_reg;
  reg [7:0]  sys_reg;
  reg [7:0]  chan_reg;
  reg [23:0] press_reg;
  reg [15:0] temp_reg;
  reg [7:0]  ptr_reg;
  reg [5:0]  bs_reg;
  reg [7:0]  sh_reg;
  reg [3:0]  bit_reg;
  reg        rw_reg;
  reg        have_ptr_reg;
  reg        wr_pend_reg;
  reg [7:0]  wr_data_reg;
  reg        wr_from_bus_reg;
  reg [4:0]  st_reg;
  reg [31:0] cnt_reg;
  reg [3:0]  idle_n_reg;

  // Result formatting
  reg [23:0] p_fmt;
  reg [15:0] t_fmt;
  always @* begin
    if (sys_reg[`PSR_SYS_RAW]) begin
      p_fmt = adc_press_i;
      t_fmt = adc_temp_i;
      if (sys_reg[`PSR_SYS_UNSIGNED]) begin
        p_fmt = {~adc_press_i[23], adc_press_i[22:0]};
        t_fmt = {~adc_temp_i[15], adc_temp_i[14:0]};
      end
    end else begin
      p_fmt = cal_press_i;
      t_fmt = cal_temp_i;
    end
  end

  reg [7:0] rd_data;
  always @* begin
    case (ptr_reg)
      `PSR_REG_P_HIGH: rd_data = press_reg[23:16];
      `PSR_REG_P_MID:  rd_data = press_reg[15:8];
      `PSR_REG_P_LOW:  rd_data = press_reg[7:0];
      `PSR_REG_T_HIGH: rd_data = temp_reg[15:8];
      `PSR_REG_T_LOW:  rd_data = temp_reg[7:0];
      `PSR_REG_CMD:    rd_data = cmd_reg;
      `PSR_REG_SYS:    rd_data = sys_reg;
      `PSR_REG_CHAN:   rd_data = chan_reg;
      default:         rd_data = 8'h00;
    endcase
  end

  // Bus target
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s_reg    <= 2'b11;
      sda_s_reg    <= 2'b11;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      bs_reg       <= BS_IDLE;
      sh_reg       <= 8'h00;
      bit_reg      <= 4'h0;
      rw_reg       <= 1'b0;
      have_ptr_reg <= 1'b0;
      ptr_reg      <= 8'h00;
      wr_pend_reg  <= 1'b0;
      wr_data_reg  <= 8'h00;
      sda_o        <= 1'b0;
      sda_oe_o     <= 1'b0;
    end else if (ce_i) begin
      scl_s_reg <= {scl_s_reg[0], scl_i};
      sda_s_reg <= {sda_s_reg[0], sda_i};
      scl_d_reg <= scl_w;
      sda_d_reg <= sda_w;
      wr_pend_reg <= 1'b0;
      if (start_det) begin
        bs_reg       <= BS_ADDR;
        bit_reg      <= 4'h0;
        have_ptr_reg <= 1'b0;
        sda_oe_o     <= 1'b0;
      end else if (stop_det) begin
        bs_reg   <= BS_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (bs_reg)
          BS_IDLE: sda_oe_o <= 1'b0;
          BS_ADDR, BS_RX: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_w};
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (bs_reg == BS_ADDR) begin
                if (sh_reg[7:1] == `PSR_I2C_ADDR) begin
                  rw_reg   <= sh_reg[0];
                  sda_oe_o <= 1'b1;
                  bs_reg   <= BS_ACK;
                end else begin
                  bs_reg <= BS_IDLE;
                end
              end else begin
                sda_oe_o <= 1'b1;
                bs_reg   <= BS_ACK;
                rw_reg   <= 1'b0;
                if (!have_ptr_reg) begin
                  ptr_reg      <= sh_reg;
                  have_ptr_reg <= 1'b1;
                end else begin
                  wr_data_reg <= sh_reg;
                  wr_pend_reg <= 1'b1;
                end
              end
            end
          end
          BS_ACK: begin
            if (scl_fall) begin
              bit_reg <= 4'h0;
              if (rw_reg) begin
                sh_reg   <= {rd_data[6:0], 1'b0};
                sda_oe_o <= ~rd_data[7];
                bs_reg   <= BS_TX;
              end else begin
                sda_oe_o <= 1'b0;
                bs_reg   <= BS_RX;
              end
            end
          end
          BS_TX: begin
            if (scl_fall) begin
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h7) begin
                sda_oe_o <= 1'b0;
                bs_reg   <= BS_MACK;
              end else begin
                sda_oe_o <= ~sh_reg[7];
                sh_reg   <= {sh_reg[6:0], 1'b0};
              end
            end
          end
          BS_MACK: begin
            if (scl_rise) begin
              bs_reg <= sda_w ? BS_IDLE : BS_ACK;
            end
          end
          default: bs_reg <= BS_IDLE;
        endcase
      end
    end
  end

  // Conversion sequencer and register file
  wire start_now = cmd_reg[`PSR_START_BIT];
  wire [2:0] kind = cmd_reg[2:0];
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_reg      <= `PSR_CMD_RESET;
      sys_reg      <= `PSR_SYS_RESET;
      chan_reg     <= `PSR_CHAN_RESET;
      press_reg    <= 24'h000000;
      temp_reg     <= 16'h0000;
      st_reg       <= ST_IDLE;
      cnt_reg      <= 32'h0;
      idle_n_reg   <= 4'h0;
      conv_temp_o  <= 1'b0;
      conv_press_o <= 1'b0;
      reg_3v6_o    <= 1'b0;
      diag_en_o    <= 1'b0;
      in_swap_o    <= 1'b0;
      gain_o       <= 8'h01;
      osr_o        <= 16'h0400;
    end else if (ce_i) begin
      reg_3v6_o <= sys_reg[`PSR_SYS_REGSEL];
      diag_en_o <= sys_reg[`PSR_SYS_DIAG];
      in_swap_o <= chan_reg[`PSR_CHAN_SWAP];
      gain_o    <= 8'h01 << chan_reg[5:3];
      osr_o     <= osr_map(chan_reg[2:0]);
      conv_temp_o  <= (st_reg == ST_TEMP);
      conv_press_o <= (st_reg == ST_PRES);
      case (st_reg)
        ST_IDLE: begin
          if (start_now && (kind == `PSR_KIND_COMBINED ||
                            kind == `PSR_KIND_SLEEP)) begin
            st_reg  <= ST_TEMP;
            cnt_reg <= 32'h0;
          end
        end
        ST_TEMP: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= CONV_CYC - 32'h1) begin
            temp_reg <= t_fmt;
            cnt_reg  <= 32'h0;
            st_reg   <= ST_PRES;
          end
        end
        ST_PRES: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= CONV_CYC - 32'h1) begin
            press_reg  <= p_fmt;
            cnt_reg    <= 32'h0;
            idle_n_reg <= 4'h0;
            st_reg     <= (kind == `PSR_KIND_SLEEP && start_now) ?
                          ST_WAIT : ST_DONE;
          end
        end
        ST_WAIT: begin
          if (!start_now) begin
            st_reg <= ST_IDLE;
          end else if (idle_n_reg == cmd_reg[7:4]) begin
            st_reg  <= ST_TEMP;
            cnt_reg <= 32'h0;
          end else if (cnt_reg >= IDLE_STEP_CYC - 32'h1) begin
            cnt_reg    <= 32'h0;
            idle_n_reg <= idle_n_reg + 4'h1;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        ST_DONE: st_reg <= ST_IDLE;
        default: st_reg <= ST_IDLE;
      endcase
      if (st_reg == ST_DONE) begin
        cmd_reg[`PSR_START_BIT] <= 1'b0;
      end
      if (wr_pend_reg) begin
        case (ptr_reg)
          `PSR_REG_CMD:  cmd_reg  <= wr_data_reg;
          `PSR_REG_SYS:  sys_reg  <= wr_data_reg;
          `PSR_REG_CHAN: chan_reg <= wr_data_reg;
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/psr_host.sv ====
// Bus master model driving register transfers into the readout block
`timescale 1ns/1ns
`default_nettype none
module psr_host (
  output var logic scl_o,    // Bus clock, idles high
  output var logic sda_oe_o, // High pulls data low
  input  wire logic sda_i    // Resolved data line
);
  logic [7:0] rbyte;
  event       got;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Start or repeated start; clock stands high between frames
  task automatic st();
    #31 sda_oe_o = 1'b0;
    #31 scl_o = 1'b1;
    #31 sda_oe_o = 1'b1;
    #32 scl_o = 1'b0;
  endtask
  task automatic sp();
    #31 sda_oe_o = 1'b1;
    #31 scl_o = 1'b1;
    #31 sda_oe_o = 1'b0;
    #32;
  endtask
  // Nine bits each way, data moved only while the clock is low
  task automatic bits(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #31 sda_oe_o = !d[i];
      #31 scl_o = 1'b1;
      #31 r[i] = sda_i;
      #32 scl_o = 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] ra,
                    input logic [7:0] d, output logic ack);
    logic [8:0] r0, r1, r2;
    st();
    bits({a, 1'b0, 1'b1}, r0);
    bits({ra, 1'b1}, r1);
    bits({d, 1'b1}, r2);
    sp();
    ack = !r0[0] && !r1[0] && !r2[0];
  endtask
  task automatic rd(input logic [7:0] ra, input logic tell);
    logic [8:0] r;
    st();
    bits({7'h6D, 1'b0, 1'b1}, r);
    bits({ra, 1'b1}, r);
    st();
    bits({7'h6D, 1'b1, 1'b1}, r);
    bits(9'h1FF, r);
    sp();
    rbyte = r[8:1];
    if (tell)
      -> got;
  endtask
endmodule
`default_nettype wire

// ==== sim/psr_readout_asserts.sv ====
// Port checks for the readout block
`timescale 1ns/1ns
`default_nettype none
module psr_readout_asserts #(
  parameter [31:0] CONV_CYC      = 32'd20,
  parameter [31:0] IDLE_STEP_CYC = 32'd10
) (
  input wire logic        clk_i,        // Clock
  input wire logic        rst_i,        // Reset
  input wire logic        scl_i,        // Bus clock
  input wire logic        sda_oe_o,     // Data pull-down
  input wire logic        conv_temp_o,  // Temp phase
  input wire logic        conv_press_o, // Pressure phase
  input wire logic        reg_3v6_o,    // Regulator select
  input wire logic        diag_en_o,    // Diagnosis on
  input wire logic        in_swap_o,    // Input swap
  input wire logic [7:0]  gain_o,       // Gain
  input wire logic [15:0] osr_o         // Oversampling
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] pc;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      pc <= 32'h0;
    else
      pc <= conv_press_o ? pc + 32'h1 : 32'h0;
  end
  chk_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data driver changed with bus clock high");
  chk_temp_press: assert property ($fell(conv_temp_o) |-> ##[0:1] conv_press_o)
    else $error("pressure phase did not follow temperature");
  chk_phase_excl: assert property (!(conv_temp_o && conv_press_o))
    else $error("both conversion phases active");
  chk_press_len: assert property ($fell(conv_press_o) |-> pc == CONV_CYC)
    else $error("pressure phase length wrong");
  chk_gain_pow: assert property ($onehot(gain_o))
    else $error("gain not a power of two");
  chk_osr_legal: assert property ($onehot(osr_o) && osr_o[7:0] == 8'h00)
    else $error("oversampling ratio illegal");
  chk_cfg_on_ack: assert property ($changed({gain_o, osr_o, in_swap_o, reg_3v6_o}) |-> sda_oe_o)
    else $error("config changed outside a write");
  chk_diag_wake: assert property ($fell(rst_i) |-> ##[0:2] diag_en_o)
    else $error("diagnosis not on after reset");
  cover property ($fell(conv_press_o));
  cover property ($rose(sda_oe_o));
  cover property ($changed(gain_o));
endmodule
bind psr_readout psr_readout_asserts #(
  .CONV_CYC(CONV_CYC), .IDLE_STEP_CYC(IDLE_STEP_CYC)
) u_chk (.clk_i, .rst_i, .scl_i, .sda_oe_o, .conv_temp_o, .conv_press_o,
  .reg_3v6_o, .diag_en_o, .in_swap_o, .gain_o, .osr_o);
`default_nettype wire

// ==== sim/psr_readout_tb.sv ====
// Self-checking bench for the readout block
`timescale 1ns/1ns
`default_nettype none
module psr_readout_tb;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, ack, lastp;
  logic [23:0] adc_press_i = 0, cal_press_i = 0, p;
  logic [15:0] adc_temp_i = 0, cal_temp_i = 0, t, e;
  logic [7:0]  v;
  logic [31:0] rs = 64387;
  logic [15:0] osr_tab [8] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
                               16'h0100, 16'h0200, 16'h4000, 16'h8000};
  logic [7:0]  sysv [3] = '{8'h13, 8'h05, 8'h0F};
  logic [15:0] q[$];
  int          n_fail = 0, cmp_count = 0, k, gap = 0;
  wire logic   sda_o, sda_oe_o, conv_temp_o, conv_press_o, scl, h_oe;
  wire logic   reg_3v6_o, diag_en_o, in_swap_o;
  wire logic [7:0]  gain_o;
  wire logic [15:0] osr_o;
  wire logic   sda = !((sda_oe_o & !sda_o) | h_oe);
  always #4 clk_i = ~clk_i;
  psr_readout #(.CONV_CYC(500), .IDLE_STEP_CYC(10)) u_dut (.clk_i, .rst_i,
    .ce_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o, .adc_press_i,
    .adc_temp_i, .cal_press_i, .cal_temp_i, .conv_temp_o, .conv_press_o,
    .reg_3v6_o, .diag_en_o, .in_swap_o, .gain_o, .osr_o);
  psr_host u_host (.scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(logic [7:0] r, logic [7:0] x);
    q.push_back({r, x});
    u_host.rd(r, 1'b1);
  endtask
  task automatic wr(logic [7:0] r, logic [7:0] d);
    u_host.wr(7'h6D, r, d, ack);
    chk("ack", ack, 1);
    @(negedge clk_i);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(u_host.got) begin
    e = q.pop_front();
    chk($sformatf("reg %h", e[15:8]), u_host.rbyte, e[7:0]);
  end
  initial begin
    #600000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 0;
    repeat (4) @(negedge clk_i);
    rd(8'hA5, 8'h02);
    rd(8'hA6, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h0A, 8'h00);
    u_host.wr(7'h6C, 8'hA6, 8'h3F, ack);
    chk("foreign ack", ack, 0);
    // Frozen block must neither answer nor store
    @(negedge clk_i);
    ce_i = 0;
    u_host.wr(7'h6D, 8'hA6, 8'h3F, ack);
    chk("frozen ack", ack, 0);
    @(negedge clk_i);
    ce_i = 1;
    rd(8'hA6, 8'h00);
    for (k = 0; k < 8; k++) begin
      v = 8'(xs());
      v[5:0] = {k[2:0], ~k[2:0]};
      wr(8'hA6, v);
      chk("gain", gain_o, 24'(8'h01 << k));
      chk("osr", osr_o, osr_tab[~k[2:0]]);
      chk("swap", in_swap_o, v[6]);
    end
    for (k = 0; k < 3; k++) begin
      wr(8'hA5, sysv[k]);
      chk("ldo", reg_3v6_o, sysv[k][4]);
      chk("diag", diag_en_o, sysv[k][1]);
      adc_press_i = 24'(xs());
      adc_temp_i = 16'(xs());
      cal_press_i = 24'(xs());
      cal_temp_i = 16'(xs());
      wr(8'h30, 8'h0A);
      rd(8'h30, 8'h0A);
      for (int i = 0; i < 20; i++) begin
        u_host.rd(8'h30, 1'b0);
        if (u_host.rbyte[3] === 1'b0)
          break;
      end
      rd(8'h30, 8'h02);
      p = k == 0 ? cal_press_i : adc_press_i;
      t = k == 0 ? cal_temp_i : adc_temp_i;
      if (k == 2) begin
        p[23] = ~p[23];
        t[15] = ~t[15];
      end
      rd(8'h06, p[23:16]);
      rd(8'h07, p[15:8]);
      rd(8'h08, p[7:0]);
      rd(8'h09, t[15:8]);
      rd(8'h0A, t[7:0]);
    end
    wr(8'h06, ~p[23:16]);
    rd(8'h06, p[23:16]);
    rd(8'h55, 8'h00);
    wr(8'h30, 8'h1B);
    k = 0;
    lastp = 0;
    for (int i = 0; i < 4000 && k < 2; i++) begin
      @(negedge clk_i);
      if (lastp && !conv_press_o)
        k++;
      if (k == 1 && !conv_temp_o && !conv_press_o)
        gap++;
      lastp = conv_press_o;
    end
    chk("sleep runs", k, 2);
    chk("idle gap", 24'(gap >= 10 && gap <= 12), 1);
    rd(8'h30, 8'h1B);
    wr(8'h30, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
